// ### verilog/csp_clock_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module csp_clock_ctrl
  import csp_pkg::*;
#(
  parameter int ELS_START = csp_pkg::ELS_START_CYC,
  parameter int PLL_LOCK  = csp_pkg::PLL_LOCK_CYC
) (
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output var  logic [31:0] RDATA,
  output var  logic        IRQ,
  output var  logic        IRC_FAST_EN,
  output var  logic        HS_CRYSTAL_EN,
  output var  logic        LS_CRYSTAL_EN,
  output var  logic        HS_CRYSTAL_DRIVE,
  output var  logic        PLL_EN,
  output var  logic [1:0]  PLL_REF_SEL,
  output var  logic        PLL_FRONT_DIV,
  output var  logic [2:0]  PLL_POST_DIV,
  output var  logic [4:0]  PLL_MULT,
  output var  logic [2:0]  SYSCLK_ACTIVE
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // source index for ready tracking: 0 fast RC, 1 hs crystal, 2 ls crystal, 3 pll
  typedef struct packed {
    logic                  hs_crystal_drive_range;
    logic                  hs_crystal_enable;
    logic                  ls_crystal_enable;
    logic                  internal_rc_fast_enable;
    logic                  pll_enable_bit;
    logic [1:0]            pll_reference_select;
    logic                  pll_front_divider_select;
    logic [2:0]            pll_post_select;
    logic [4:0]            pll_feedback_multiplier;
    logic [2:0]            system_clock_select;
    logic [2:0]            active_src;
    logic [3:0]            rdy;
    logic [3:0][CNT_W-1:0] cnt;
    logic [4:0]            ists;
    logic [4:0]            imask;
    logic [31:0]           rdata;
    logic                  irq;
  } csp_state_t;

  csp_state_t state_reg;
  csp_state_t state_next;

  logic [3:0]            en_vec;
  logic [3:0]            run_vec;
  logic [3:0][CNT_W-1:0] lim_vec;
  logic                  pll_in_use;
  logic                  prot_irc;
  logic                  prot_ehs;
  logic                  prot_els;
  logic                  prot_pll;

  function automatic logic src_ready(input logic [2:0] code, input logic [3:0] rdy);
    logic r;
    r = 1'b0;
    case (code)
      SRC_IRC:  r = rdy[0];
      SRC_INTERNAL_RC_SLOW: r = 1'b1;
      SRC_EHS:  r = rdy[1];
      SRC_ELS:  r = rdy[2];
      SRC_PLL:  r = rdy[3];
      default:  r = 1'b0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // protection and startup
  // ----------------------------------------------------------------
  always_comb begin
    // a source feeding the pll is in use whenever the pll is
    pll_in_use = (state_reg.active_src == SRC_PLL) || (state_reg.system_clock_select == SRC_PLL);
    prot_irc = (state_reg.active_src == SRC_IRC) || (state_reg.system_clock_select == SRC_IRC)
               || (pll_in_use && state_reg.pll_reference_select == REF_IRC);
    prot_ehs = (state_reg.active_src == SRC_EHS) || (state_reg.system_clock_select == SRC_EHS)
               || (pll_in_use && state_reg.pll_reference_select == REF_EHS);
    prot_els = (state_reg.active_src == SRC_ELS) || (state_reg.system_clock_select == SRC_ELS);
    prot_pll = pll_in_use;
    en_vec = {state_reg.pll_enable_bit, state_reg.ls_crystal_enable,
              state_reg.hs_crystal_enable, state_reg.internal_rc_fast_enable};
    lim_vec[0] = CNT_W'(IRC_START_CYC);
    lim_vec[1] = CNT_W'(EHS_START_CYC);
    lim_vec[2] = CNT_W'(ELS_START);
    lim_vec[3] = CNT_W'(PLL_LOCK);
    run_vec = en_vec;
    // pll cannot lock without a ready reference
    if (state_reg.pll_reference_select == REF_IRC) begin
      run_vec[3] = en_vec[3] & state_reg.rdy[0];
    end else if (state_reg.pll_reference_select == REF_EHS) begin
      run_vec[3] = en_vec[3] & state_reg.rdy[1];
    end else begin
      run_vec[3] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.rdata = 32'h0000_0000;
    // ready tracking per source
    for (int i = 0; i < 4; i++) begin
      if (!run_vec[i]) begin
        state_next.cnt[i] = '0;
        state_next.rdy[i] = 1'b0;
      end else if (!state_reg.rdy[i]) begin
        if (state_reg.cnt[i] >= lim_vec[i] - CNT_W'(1)) begin
          state_next.rdy[i] = 1'b1;
        end else begin
          state_next.cnt[i] = state_reg.cnt[i] + CNT_W'(1);
        end
      end
    end
    // deferred switch: reserved codes never become active
    if (state_reg.system_clock_select != state_reg.active_src
        && src_ready(state_reg.system_clock_select, state_reg.rdy)) begin
      state_next.active_src = state_reg.system_clock_select;
    end
    // register writes
    if (WR) begin
      if (ADDR == OSC_CTRL_OFS) begin
        state_next.hs_crystal_drive_range = WDATA[OSC_EHS_DRV_BIT];
        state_next.hs_crystal_enable = WDATA[OSC_EHS_EN_BIT] | prot_ehs;
        state_next.ls_crystal_enable = WDATA[OSC_ELS_EN_BIT] | prot_els;
        state_next.internal_rc_fast_enable = WDATA[OSC_IRC_EN_BIT] | prot_irc;
      end else if (ADDR == PLL_CFG_OFS) begin
        state_next.pll_enable_bit = WDATA[PLL_EN_BIT] | prot_pll;
        state_next.pll_reference_select = WDATA[PLL_REF_LSB +: 2];
        state_next.pll_front_divider_select = WDATA[PLL_FRONT_BIT];
        state_next.pll_post_select = WDATA[PLL_POST_LSB +: 3];
        state_next.pll_feedback_multiplier = WDATA[PLL_MULT_LSB +: 5];
      end else if (ADDR == SYS_SEL_OFS) begin
        state_next.system_clock_select = WDATA[2:0];
      end else if (ADDR == IRQ_STAT_OFS) begin
        state_next.ists = state_reg.ists & ~WDATA[4:0];
      end else if (ADDR == IRQ_MASK_OFS) begin
        state_next.imask = WDATA[4:0];
      end
      // ready status register is read only: writes fall through here
    end
    // events after the clear so a simultaneous set wins
    state_next.ists = state_next.ists | {1'b0, state_next.rdy & ~state_reg.rdy};
    if (state_next.active_src != state_reg.active_src) begin
      state_next.ists[4] = 1'b1;
    end
    state_next.irq = |(state_next.ists & state_next.imask);
    // reads, reserved bits zero
    if (RD) begin
      if (ADDR == OSC_CTRL_OFS) begin
        state_next.rdata[OSC_EHS_DRV_BIT] = state_reg.hs_crystal_drive_range;
        state_next.rdata[OSC_EHS_EN_BIT] = state_reg.hs_crystal_enable;
        state_next.rdata[OSC_ELS_EN_BIT] = state_reg.ls_crystal_enable;
        state_next.rdata[OSC_IRC_EN_BIT] = state_reg.internal_rc_fast_enable;
      end else if (ADDR == PLL_CFG_OFS) begin
        state_next.rdata[PLL_EN_BIT] = state_reg.pll_enable_bit;
        state_next.rdata[PLL_REF_LSB +: 2] = state_reg.pll_reference_select;
        state_next.rdata[PLL_FRONT_BIT] = state_reg.pll_front_divider_select;
        state_next.rdata[PLL_POST_LSB +: 3] = state_reg.pll_post_select;
        state_next.rdata[PLL_MULT_LSB +: 5] = state_reg.pll_feedback_multiplier;
      end else if (ADDR == RDY_STAT_OFS) begin
        state_next.rdata[RDY_PLL_BIT] = state_reg.rdy[3];
        state_next.rdata[RDY_EHS_BIT] = state_reg.rdy[1];
        state_next.rdata[RDY_ELS_BIT] = state_reg.rdy[2];
        state_next.rdata[RDY_IRC_BIT] = state_reg.rdy[0];
      end else if (ADDR == SYS_SEL_OFS) begin
        state_next.rdata[2:0] = state_reg.system_clock_select;
        state_next.rdata[SEL_ACT_LSB +: 3] = state_reg.active_src;
      end else if (ADDR == IRQ_STAT_OFS) begin
        state_next.rdata[4:0] = state_reg.ists;
      end else if (ADDR == IRQ_MASK_OFS) begin
        state_next.rdata[4:0] = state_reg.imask;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      state_reg <= '0;
      state_reg.internal_rc_fast_enable <= IRC_EN_RST;
      state_reg.pll_post_select <= PLL_POST_RST;
      state_reg.pll_feedback_multiplier <= PLL_MULT_RST;
      state_reg.rdy <= RDY_RST;
    end else if (CE) begin
      state_reg <= state_next;
    end
  end

  assign RDATA            = state_reg.rdata;
  assign IRQ              = state_reg.irq;
  assign IRC_FAST_EN      = state_reg.internal_rc_fast_enable;
  assign HS_CRYSTAL_EN    = state_reg.hs_crystal_enable;
  assign LS_CRYSTAL_EN    = state_reg.ls_crystal_enable;
  assign HS_CRYSTAL_DRIVE = state_reg.hs_crystal_drive_range;
  assign PLL_EN           = state_reg.pll_enable_bit;
  assign PLL_REF_SEL      = state_reg.pll_reference_select;
  assign PLL_FRONT_DIV    = state_reg.pll_front_divider_select;
  assign PLL_POST_DIV     = state_reg.pll_post_select;
  assign PLL_MULT         = state_reg.pll_feedback_multiplier;
  assign SYSCLK_ACTIVE    = state_reg.active_src;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_irc_clear_block: assert property (@(posedge MCLK) disable iff (RST)
    (CE && WR && ADDR == OSC_CTRL_OFS && !WDATA[OSC_IRC_EN_BIT] && prot_irc)
    |=> IRC_FAST_EN)
    else $error("protected fast RC enable was cleared");

  a_pll_clear_block: assert property (@(posedge MCLK) disable iff (RST)
    (CE && WR && ADDR == PLL_CFG_OFS && !WDATA[PLL_EN_BIT] && prot_pll)
    |=> PLL_EN)
    else $error("protected pll enable was cleared");

  a_drive_write: assert property (@(posedge MCLK) disable iff (RST)
    (CE && WR && ADDR == OSC_CTRL_OFS) |=> HS_CRYSTAL_DRIVE == $past(WDATA[OSC_EHS_DRV_BIT]))
    else $error("crystal drive range not written");

  a_post_write: assert property (@(posedge MCLK) disable iff (RST)
    (CE && WR && ADDR == PLL_CFG_OFS) |=> PLL_POST_DIV == $past(WDATA[7:5])
      && PLL_MULT == $past(WDATA[4:0]))
    else $error("pll divider fields not written");

  a_ready_drop: assert property (@(posedge MCLK) disable iff (RST)
    (CE && !HS_CRYSTAL_EN) |=> !state_reg.rdy[1])
    else $error("crystal ready while disabled");

  a_lock_needs_en: assert property (@(posedge MCLK) disable iff (RST)
    $rose(state_reg.rdy[3]) |-> $past(PLL_EN) && $past(state_reg.cnt[3]) != '0)
    else $error("pll locked without enable and settling");

  a_switch_ready: assert property (@(posedge MCLK) disable iff (RST)
    $changed(SYSCLK_ACTIVE) |-> $past(src_ready(state_reg.system_clock_select, state_reg.rdy))
      && SYSCLK_ACTIVE == $past(state_reg.system_clock_select))
    else $error("clock switched to an unready source");

  a_status_read: assert property (@(posedge MCLK) disable iff (RST)
    (CE && RD && ADDR == RDY_STAT_OFS) |=> RDATA[31:7] == '0 && RDATA[5] == 1'b0
      && RDATA[0] == $past(state_reg.rdy[0]))
    else $error("status read shows reserved bits or wrong ready");

  a_irq_level: assert property (@(posedge MCLK) disable iff (RST)
    IRQ == |(state_reg.ists & state_reg.imask))
    else $error("interrupt output disagrees with status and mask");

  a_hs_enable_write: assert property (@(posedge MCLK) disable iff (RST)
    (CE && WR && ADDR == OSC_CTRL_OFS && !prot_ehs)
    |=> HS_CRYSTAL_EN == $past(WDATA[OSC_EHS_EN_BIT]))
    else $error("high-speed crystal enable not written");

  a_ls_enable_write: assert property (@(posedge MCLK) disable iff (RST)
    (CE && WR && ADDR == OSC_CTRL_OFS && !prot_els)
    |=> LS_CRYSTAL_EN == $past(WDATA[OSC_ELS_EN_BIT]))
    else $error("low-speed crystal enable not written");

  a_rc_enable_write: assert property (@(posedge MCLK) disable iff (RST)
    (CE && WR && ADDR == OSC_CTRL_OFS && !prot_irc)
    |=> IRC_FAST_EN == $past(WDATA[OSC_IRC_EN_BIT]))
    else $error("fast RC enable not written");

  a_pll_enable_write: assert property (@(posedge MCLK) disable iff (RST)
    (CE && WR && ADDR == PLL_CFG_OFS && !prot_pll)
    |=> PLL_EN == $past(WDATA[PLL_EN_BIT]))
    else $error("unprotected pll enable not written");

  a_ref_write: assert property (@(posedge MCLK) disable iff (RST)
    (CE && WR && ADDR == PLL_CFG_OFS) |=> PLL_REF_SEL == $past(WDATA[13:12]))
    else $error("pll reference select not written");

  a_front_write: assert property (@(posedge MCLK) disable iff (RST)
    (CE && WR && ADDR == PLL_CFG_OFS) |=> PLL_FRONT_DIV == $past(WDATA[PLL_FRONT_BIT]))
    else $error("pll front divider not written");

  a_mult_write: assert property (@(posedge MCLK) disable iff (RST)
    (CE && WR && ADDR == PLL_CFG_OFS) |=> PLL_MULT == $past(WDATA[4:0]))
    else $error("pll feedback multiplier not written");

  a_lock_read: assert property (@(posedge MCLK) disable iff (RST)
    (CE && RD && ADDR == RDY_STAT_OFS) |=> RDATA[RDY_PLL_BIT] == $past(state_reg.rdy[3]))
    else $error("status read shows wrong pll lock");

  a_hs_ready_read: assert property (@(posedge MCLK) disable iff (RST)
    (CE && RD && ADDR == RDY_STAT_OFS) |=> RDATA[RDY_EHS_BIT] == $past(state_reg.rdy[1]))
    else $error("status read shows wrong high-speed crystal ready");

  a_ls_ready_read: assert property (@(posedge MCLK) disable iff (RST)
    (CE && RD && ADDR == RDY_STAT_OFS) |=> RDATA[RDY_ELS_BIT] == $past(state_reg.rdy[2]))
    else $error("status read shows wrong low-speed crystal ready");

  a_ls_ready_drop: assert property (@(posedge MCLK) disable iff (RST)
    (CE && !LS_CRYSTAL_EN) |=> !state_reg.rdy[2])
    else $error("low-speed crystal ready while disabled");

  a_select_write: assert property (@(posedge MCLK) disable iff (RST)
    (CE && WR && ADDR == SYS_SEL_OFS) |=> state_reg.system_clock_select == $past(WDATA[2:0]))
    else $error("system clock select not written");

  a_select_legal: assert property (@(posedge MCLK) disable iff (RST)
    SYSCLK_ACTIVE <= SRC_PLL)
    else $error("reserved source became the system clock");

  a_rdata_idle: assert property (@(posedge MCLK) disable iff (RST)
    (CE && !RD) |=> RDATA == 32'h0000_0000)
    else $error("read data stood without a read");

endmodule // csp_clock_ctrl
`default_nettype wire

// ### include/csp_pkg.sv
`default_nettype none
package csp_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OSC_CTRL_OFS  = 8'h00;
  localparam logic [7:0] PLL_CFG_OFS   = 8'h04;
  localparam logic [7:0] RDY_STAT_OFS  = 8'h08;
  localparam logic [7:0] SYS_SEL_OFS   = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h14;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OSC_IRC_EN_BIT   = 0;
  localparam int OSC_ELS_EN_BIT   = 2;
  localparam int OSC_EHS_EN_BIT   = 4;
  localparam int OSC_EHS_DRV_BIT  = 5;
  localparam int PLL_MULT_LSB     = 0;
  localparam int PLL_POST_LSB     = 5;
  localparam int PLL_FRONT_BIT    = 8;
  localparam int PLL_REF_LSB      = 12;
  localparam int PLL_EN_BIT       = 15;
  localparam int RDY_IRC_BIT      = 0;
  localparam int RDY_ELS_BIT      = 2;
  localparam int RDY_EHS_BIT      = 4;
  localparam int RDY_PLL_BIT      = 6;
  localparam int SEL_ACT_LSB      = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic       IRC_EN_RST   = 1'b1;
  localparam logic [2:0] PLL_POST_RST = 3'h3;
  localparam logic [4:0] PLL_MULT_RST = 5'h03;
  localparam logic [3:0] RDY_RST      = 4'h1;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_IRC  = 3'h0;
  localparam logic [2:0] SRC_INTERNAL_RC_SLOW = 3'h1;
  localparam logic [2:0] SRC_EHS  = 3'h2;
  localparam logic [2:0] SRC_ELS  = 3'h3;
  localparam logic [2:0] SRC_PLL  = 3'h4;
  localparam logic [1:0] REF_IRC  = 2'h0;
  localparam logic [1:0] REF_EHS  = 2'h1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 125;
  localparam int IRC_START_NS   = 1000;
  localparam int EHS_START_NS   = 16000;
  localparam int ELS_START_US   = 1000;
  localparam int PLL_LOCK_US    = 100;
  localparam int IRC_START_CYC  = (IRC_START_NS * CLK_MHZ + 999) / 1000;
  localparam int EHS_START_CYC  = (EHS_START_NS * CLK_MHZ + 999) / 1000;
  localparam int ELS_START_CYC  = ELS_START_US * CLK_MHZ;
  localparam int PLL_LOCK_CYC   = PLL_LOCK_US * CLK_MHZ;
  localparam int CNT_W          = 20;
endpackage
`default_nettype wire

// ### verification/csp_clock_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import csp_pkg::*;
  // ----------------------------------------------------------------
  // set-up
  // ----------------------------------------------------------------
  // short startup counts keep the run well under the cycle budget
  localparam int ELS_T = 20;
  localparam int PLL_T = 30;
  logic        MCLK = 1'b0;
  logic        RST = 1'b1;
  logic        CE = 1'b1;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic [7:0]  ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  wire  logic [31:0] RDATA;
  wire  logic        IRQ, IRC_FAST_EN, HS_CRYSTAL_EN, LS_CRYSTAL_EN, HS_CRYSTAL_DRIVE, PLL_EN;
  wire  logic        PLL_FRONT_DIV;
  wire  logic [1:0]  PLL_REF_SEL;
  wire  logic [2:0]  PLL_POST_DIV, SYSCLK_ACTIVE;
  wire  logic [4:0]  PLL_MULT;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [31:0] rv;
  csp_clock_ctrl #(.ELS_START(ELS_T), .PLL_LOCK(PLL_T)) dut_u (
    .MCLK(MCLK), .RST(RST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .IRQ(IRQ), .IRC_FAST_EN(IRC_FAST_EN), .HS_CRYSTAL_EN(HS_CRYSTAL_EN),
    .LS_CRYSTAL_EN(LS_CRYSTAL_EN), .HS_CRYSTAL_DRIVE(HS_CRYSTAL_DRIVE), .PLL_EN(PLL_EN),
    .PLL_REF_SEL(PLL_REF_SEL), .PLL_FRONT_DIV(PLL_FRONT_DIV), .PLL_POST_DIV(PLL_POST_DIV),
    .PLL_MULT(PLL_MULT), .SYSCLK_ACTIVE(SYSCLK_ACTIVE));
  always #4 MCLK = ~MCLK;
  // ----------------------------------------------------------------
  // common tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge MCLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic wait_stat(input int b, input int lim);
    int n;
    n = 0;
    rv = 32'h0;
    while (rv[b] !== 1'b1 && n < lim) begin
      rd(RDY_STAT_OFS, rv);
      n++;
    end
    chk("ready flag", 32'(rv[b]), 32'h1);
  endtask
  task automatic wait_active(input logic [2:0] code, input int lim);
    int n;
    n = 0;
    while (SYSCLK_ACTIVE !== code && n < lim) begin
      @(posedge MCLK);
      #1 n++;
    end
    chk("active source", 32'(SYSCLK_ACTIVE), 32'(code));
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(OSC_CTRL_OFS, rv); chk("osc reset", rv, 32'h0000_0001);
    rd(PLL_CFG_OFS, rv);  chk("pll reset", rv, 32'h0000_0063);
    rd(RDY_STAT_OFS, rv); chk("stat reset", rv, 32'h0000_0001);
    chk("active reset", 32'(SYSCLK_ACTIVE), 32'h0);
    chk("rc port", 32'({IRC_FAST_EN, HS_CRYSTAL_EN, LS_CRYSTAL_EN, PLL_EN}), 32'h8);
  endtask
  task automatic t_osc();
    wr(OSC_CTRL_OFS, 32'hFFFF_FFFF);
    rd(OSC_CTRL_OFS, rv); chk("osc all ones", rv, 32'h0000_0035);
    chk("osc ports", 32'({HS_CRYSTAL_DRIVE, HS_CRYSTAL_EN, LS_CRYSTAL_EN, IRC_FAST_EN}), 32'hF);
    wr(OSC_CTRL_OFS, 32'h0);
    rd(OSC_CTRL_OFS, rv); chk("rc kept as sysclk", rv, 32'h0000_0001);
    chk("osc ports off", 32'({HS_CRYSTAL_DRIVE, HS_CRYSTAL_EN, LS_CRYSTAL_EN}), 32'h0);
    // a frozen block ignores strobes
    @(posedge MCLK);
    CE <= 1'b0;
    wr(OSC_CTRL_OFS, 32'h0000_0010);
    CE <= 1'b1;
    #1 chk("ce low write", 32'(HS_CRYSTAL_EN), 32'h0);
    wr(RDY_STAT_OFS, 32'hFFFF_FFFF);
    rd(RDY_STAT_OFS, rv); chk("status read only", rv, 32'h0000_0001);
    rd(8'hFC, rv);        chk("unmapped", rv, 32'h0);
  endtask
  task automatic t_pll_fields();
    wr(PLL_CFG_OFS, 32'hFFFF_FFFF);
    rd(PLL_CFG_OFS, rv); chk("pll all ones", rv, 32'h0000_B1FF);
    chk("pll ports", 32'({PLL_EN, PLL_REF_SEL, PLL_FRONT_DIV, PLL_POST_DIV, PLL_MULT}), 32'hFFF);
    for (int c = 0; c < 4; c++) begin
      wr(PLL_CFG_OFS, 32'h0000_0060 | (32'(c) << 12) | 32'(c + 3));
      #1 chk("pll ref", 32'(PLL_REF_SEL), 32'(c));
      chk("pll mult", 32'(PLL_MULT), 32'(c + 3));
      chk("pll front", 32'(PLL_FRONT_DIV), 32'h0);
    end
    rd(RDY_STAT_OFS, rv); chk("no lock when off", rv, 32'h0000_0001);
  endtask
  task automatic t_ls();
    wr(OSC_CTRL_OFS, 32'h0000_0005);
    wait_stat(RDY_ELS_BIT, ELS_T + 10);
    wr(SYS_SEL_OFS, 32'h0000_0003);
    wait_active(SRC_ELS, 10);
    wr(SYS_SEL_OFS, 32'h0000_0001);
    wait_active(SRC_INTERNAL_RC_SLOW, 10);
    wr(SYS_SEL_OFS, 32'h0000_0000);
    wait_active(SRC_IRC, 10);
    wr(OSC_CTRL_OFS, 32'h0000_0001);
    rd(RDY_STAT_OFS, rv); chk("ls ready drops", rv, 32'h0000_0001);
  endtask
  task automatic t_hs_switch();
    wr(OSC_CTRL_OFS, 32'h0000_0031);
    wr(SYS_SEL_OFS, 32'h0000_0002);
    repeat (20) @(posedge MCLK);
    #1 chk("switch deferred", 32'(SYSCLK_ACTIVE), 32'h0);
    wait_stat(RDY_EHS_BIT, EHS_START_CYC);
    wait_active(SRC_EHS, 10);
    wr(IRQ_MASK_OFS, 32'h0000_0012);
    @(posedge MCLK);
    #1 chk("irq raised", 32'(IRQ), 32'h1);
    rd(IRQ_STAT_OFS, rv); chk("irq events", rv & 32'h12, 32'h12);
    wr(IRQ_STAT_OFS, 32'h0000_0012);
    @(posedge MCLK);
    #1 chk("irq cleared", 32'(IRQ), 32'h0);
    wr(OSC_CTRL_OFS, 32'h0000_0001);
    rd(OSC_CTRL_OFS, rv); chk("hs kept as sysclk", rv, 32'h0000_0011);
  endtask
  task automatic t_pll_switch();
    // 12 MHz crystal times 24 keeps the oscillator inside its band
    wr(PLL_CFG_OFS, 32'h0000_9078);
    wait_stat(RDY_PLL_BIT, PLL_T + 10);
    wr(SYS_SEL_OFS, 32'h0000_0004);
    wait_active(SRC_PLL, 10);
    wr(PLL_CFG_OFS, 32'h0000_1078);
    rd(PLL_CFG_OFS, rv); chk("pll en kept", rv, 32'h0000_9078);
    wr(OSC_CTRL_OFS, 32'h0);
    rd(OSC_CTRL_OFS, rv); chk("pll ref kept", rv, 32'h0000_0010);
    rd(RDY_STAT_OFS, rv); chk("rc ready drops", rv, 32'h0000_0050);
    wr(SYS_SEL_OFS, 32'h0);
    repeat (20) @(posedge MCLK);
    #1 chk("rc switch waits", 32'(SYSCLK_ACTIVE), 32'h4);
    wr(OSC_CTRL_OFS, 32'h0000_0011);
    wait_active(SRC_IRC, IRC_START_CYC + 20);
    wr(PLL_CFG_OFS, 32'h0000_0078);
    rd(RDY_STAT_OFS, rv); chk("pll unlock", rv, 32'h0000_0011);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    t_reset();
    t_osc();
    t_pll_fields();
    t_ls();
    t_hs_switch();
    t_pll_switch();
    conclude();
  end
endmodule // tb
`default_nettype wire
